// *** sca_pkg.sv ***
// constants, command type and decode function for the command/address decoder
package sca_pkg;

  localparam int ADDR_W     = 14;
  localparam int BANK_W     = 3;
  localparam int BANKS      = 8;
  localparam int DQ_W       = 16;
  localparam int DM_W       = 2;
  localparam int COL_W      = 10;
  localparam int MR_CNT     = 4;
  localparam int AP_BIT     = 10;
  localparam int BC_BIT     = 12;
  localparam int FIFO_DEPTH = 4;
  localparam int MEM_AW     = 4;
  localparam int MEM_DEPTH  = 16;

  localparam logic [3:0] BURST_FULL = 4'h8;
  localparam logic [3:0] BURST_CHOP = 4'h4;

  // burst length field of mode register zero
  localparam int         BL_LSB = 0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_BC4 = 2'h2;

  // termination fields of mode registers one and two
  localparam int RTT_NOM_B0 = 2;
  localparam int RTT_NOM_B1 = 6;
  localparam int RTT_NOM_B2 = 9;
  localparam int RTT_WR_LSB = 9;

  localparam logic [ADDR_W-1:0] MR_RESET = 14'h0000;
  localparam logic [DQ_W-1:0]   DQ_RESET = 16'h0000;

  // positions inside the synchronised pin vector
  localparam int POS_CKP  = 0;
  localparam int POS_CKN  = 1;
  localparam int POS_CS   = 2;
  localparam int POS_RAS  = 3;
  localparam int POS_CAS  = 4;
  localparam int POS_WE   = 5;
  localparam int POS_BA   = 6;
  localparam int POS_ADDR = 9;
  localparam int POS_ODT  = 23;
  localparam int POS_DQ   = 24;
  localparam int POS_DQSP = 40;
  localparam int POS_DQSN = 41;
  localparam int POS_DM   = 42;
  localparam int PIN_W    = 44;
  // strobes idle high after reset so no command is seen
  localparam logic [PIN_W-1:0] PIN_RST = 44'h000_0000_003C;

  typedef enum logic [7:0] {
    SCA_NOP = 8'h01,
    SCA_MRS = 8'h02,
    SCA_REF = 8'h04,
    SCA_PRE = 8'h08,
    SCA_ACT = 8'h10,
    SCA_WR  = 8'h20,
    SCA_RD  = 8'h40,
    SCA_ZQC = 8'h80
  } sca_cmd_t;

  function automatic sca_cmd_t scaDecode(input logic csN, input logic rasN,
                                         input logic casN, input logic weN);
    sca_cmd_t c;
    c = SCA_NOP;
    if (!csN) begin
      unique case ({rasN, casN, weN})
        3'h0: c = SCA_MRS;
        3'h1: c = SCA_REF;
        3'h2: c = SCA_PRE;
        3'h3: c = SCA_ACT;
        3'h4: c = SCA_WR;
        3'h5: c = SCA_RD;
        3'h6: c = SCA_ZQC;
        3'h7: c = SCA_NOP;
      endcase
    end
    return c;
  endfunction

endpackage

// *** sca_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sca_pin_sync #(
  parameter int           W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
    end else begin
      s1_ff <= pinIn;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a bit changes only once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : gFilt
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        out_ff[i] <= RST_VAL[i];
      end else if (s2_ff[i] == s3_ff[i]) begin
        out_ff[i] <= s3_ff[i];
      end
    end
  end

  assign pinOut = out_ff;

endmodule // sca_pin_sync

// *** sca_fifo.sv ***
// small valid/ready fifo for write beats
`timescale 1ns/1ps
module sca_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic      [W-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wrPtr_ff;
  logic [PW-1:0] rdPtr_ff;
  logic [PW:0]   count_ff;
  logic          doPush;
  logic          doPop;

  assign inReady  = (count_ff < (PW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData  = mem[rdPtr_ff];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (doPush) begin
        wrPtr_ff <= (wrPtr_ff == PW'(DEPTH - 1)) ? '0 : wrPtr_ff + PW'(1);
      end
      if (doPop) begin
        rdPtr_ff <= (rdPtr_ff == PW'(DEPTH - 1)) ? '0 : rdPtr_ff + PW'(1);
      end
      count_ff <= count_ff + (PW+1)'(doPush) - (PW+1)'(doPop);
    end
  end

endmodule // sca_fifo

// *** sca_cmd_addr_decode.sv ***
// command, address, mask and termination decoding inside the memory device
`timescale 1ns/1ps
module sca_cmd_addr_decode (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          ckPin,
  input  wire logic                          ckPinN,
  input  wire logic                          csPin_n,
  input  wire logic                          rasPin_n,
  input  wire logic                          casPin_n,
  input  wire logic                          wePin_n,
  input  wire logic [sca_pkg::BANK_W-1:0]    bankSelect,
  input  wire logic [sca_pkg::ADDR_W-1:0]    addrPin,
  input  wire logic                          terminationEnable,
  input  wire logic [sca_pkg::DQ_W-1:0]      dqIn,
  input  wire logic                          dqsIn,
  input  wire logic                          dqsInN,
  input  wire logic [sca_pkg::DM_W-1:0]      writeDataMask,
  output logic      [sca_pkg::DQ_W-1:0]      dqOut_ff,
  output logic                               dqOe_ff,
  output logic                               dqsOut_ff,
  output logic                               dqsOutN_ff,
  output logic                               dqsOe_ff,
  output logic                               terminationOn_ff,
  output logic      [sca_pkg::BANKS-1:0]     bankOpen_ff,
  output logic                               cmdStrobe_ff,
  output sca_pkg::sca_cmd_t                  cmdCode_ff,
  output logic      [sca_pkg::BANK_W-1:0]    cmdBank_ff,
  output logic      [sca_pkg::ADDR_W-1:0]    cmdRow_ff,
  output logic      [sca_pkg::COL_W-1:0]     cmdColumn_ff,
  output logic                               autoPrecharge_ff,
  output logic                               burstChopped_ff,
  output logic                               prechargeAll_ff,
  output logic      [sca_pkg::ADDR_W-1:0]    modeRegisterOne_ff,
  output logic      [sca_pkg::ADDR_W-1:0]    modeRegisterTwo_ff,
  output logic                               bufferReady_ff
);

  localparam int FW = sca_pkg::DM_W + sca_pkg::DQ_W + sca_pkg::MEM_AW;

  // ----------------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------------
  logic [sca_pkg::PIN_W-1:0] pinRaw;
  logic [sca_pkg::PIN_W-1:0] pinF;

  assign pinRaw = {writeDataMask, dqsInN, dqsIn, dqIn, terminationEnable, addrPin,
                   bankSelect, wePin_n, casPin_n, rasPin_n, csPin_n, ckPinN, ckPin};

  sca_pin_sync #(
    .W       (sca_pkg::PIN_W),
    .RST_VAL (sca_pkg::PIN_RST)
  ) uPinSync (
    .clk    (clk),
    .rst_n  (rst_n),
    .pinIn  (pinRaw),
    .pinOut (pinF)
  );

  logic                       ckP;
  logic                       ckN;
  logic [sca_pkg::BANK_W-1:0] bankF;
  logic [sca_pkg::ADDR_W-1:0] addrF;
  logic                       odtF;
  logic [sca_pkg::DQ_W-1:0]   dqF;
  logic                       dqsP;
  logic                       dqsN;
  logic [sca_pkg::DM_W-1:0]   dmF;
  sca_pkg::sca_cmd_t          cmdNow;

  assign ckP   = pinF[sca_pkg::POS_CKP];
  assign ckN   = pinF[sca_pkg::POS_CKN];
  assign bankF = pinF[sca_pkg::POS_BA +: sca_pkg::BANK_W];
  assign addrF = pinF[sca_pkg::POS_ADDR +: sca_pkg::ADDR_W];
  assign odtF  = pinF[sca_pkg::POS_ODT];
  assign dqF   = pinF[sca_pkg::POS_DQ +: sca_pkg::DQ_W];
  assign dqsP  = pinF[sca_pkg::POS_DQSP];
  assign dqsN  = pinF[sca_pkg::POS_DQSN];
  assign dmF   = pinF[sca_pkg::POS_DM +: sca_pkg::DM_W];
  assign cmdNow = sca_pkg::scaDecode(pinF[sca_pkg::POS_CS], pinF[sca_pkg::POS_RAS],
                                     pinF[sca_pkg::POS_CAS], pinF[sca_pkg::POS_WE]);

  // ----------------------------------------------------------------------
  // differential clock and strobe edges
  // ----------------------------------------------------------------------
  logic ckLvl_ff;
  logic dqsLvl_ff;
  logic ckRise;
  logic ckEdge;
  logic dqsEdge;

  // the level moves only when the pair has crossed
  assign ckRise  = (ckP != ckN) && ckP && !ckLvl_ff;
  assign ckEdge  = (ckP != ckN) && (ckP != ckLvl_ff);
  assign dqsEdge = (dqsP != dqsN) && (dqsP != dqsLvl_ff);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ckLvl_ff  <= 1'b0;
      dqsLvl_ff <= 1'b0;
    end else begin
      if (ckP != ckN) begin
        ckLvl_ff <= ckP;
      end
      if (dqsP != dqsN) begin
        dqsLvl_ff <= dqsP;
      end
    end
  end

  // ----------------------------------------------------------------------
  // mode registers
  // ----------------------------------------------------------------------
  logic [sca_pkg::ADDR_W-1:0] modeReg_ff [sca_pkg::MR_CNT];
  logic                       chopNow;
  logic                       rttOn;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < sca_pkg::MR_CNT; i++) begin
        modeReg_ff[i] <= sca_pkg::MR_RESET;
      end
    end else if (ckRise && cmdNow == sca_pkg::SCA_MRS) begin
      modeReg_ff[bankF[1:0]] <= addrF;
    end
  end

  assign modeRegisterOne_ff = modeReg_ff[1];
  assign modeRegisterTwo_ff = modeReg_ff[2];

  // fixed chop, or chop on the fly when the chop bit is low
  assign chopNow = (modeReg_ff[0][sca_pkg::BL_LSB +: 2] == sca_pkg::BL_BC4) ||
                   ((modeReg_ff[0][sca_pkg::BL_LSB +: 2] == sca_pkg::BL_OTF) &&
                    !addrF[sca_pkg::BC_BIT]);

  assign rttOn = modeReg_ff[1][sca_pkg::RTT_NOM_B0] || modeReg_ff[1][sca_pkg::RTT_NOM_B1] ||
                 modeReg_ff[1][sca_pkg::RTT_NOM_B2] ||
                 (modeReg_ff[2][sca_pkg::RTT_WR_LSB +: 2] != 2'h0);

  // ----------------------------------------------------------------------
  // termination
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      terminationOn_ff <= 1'b0;
    end else begin
      terminationOn_ff <= odtF && rttOn;
    end
  end

  // ----------------------------------------------------------------------
  // command capture
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmdStrobe_ff     <= 1'b0;
      cmdCode_ff       <= sca_pkg::SCA_NOP;
      cmdBank_ff       <= '0;
      cmdRow_ff        <= '0;
      cmdColumn_ff     <= '0;
      autoPrecharge_ff <= 1'b0;
      burstChopped_ff  <= 1'b0;
      prechargeAll_ff  <= 1'b0;
    end else begin
      cmdStrobe_ff <= ckRise && (cmdNow != sca_pkg::SCA_NOP);
      if (ckRise && cmdNow != sca_pkg::SCA_NOP) begin
        cmdCode_ff <= cmdNow;
        cmdBank_ff <= bankF;
        if (cmdNow == sca_pkg::SCA_ACT) begin
          cmdRow_ff <= addrF;
        end
        if (cmdNow == sca_pkg::SCA_RD || cmdNow == sca_pkg::SCA_WR) begin
          cmdColumn_ff     <= addrF[sca_pkg::COL_W-1:0];
          autoPrecharge_ff <= addrF[sca_pkg::AP_BIT];
          burstChopped_ff  <= chopNow;
        end
        prechargeAll_ff <= (cmdNow == sca_pkg::SCA_PRE) && addrF[sca_pkg::AP_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // write burst: beats captured on both strobe edges
  // ----------------------------------------------------------------------
  logic                       wrActive_ff;
  logic [3:0]                 wrBeat_ff;
  logic [3:0]                 wrLen_ff;
  logic [sca_pkg::BANK_W-1:0] wrBank_ff;
  logic [2:0]                 wrCol_ff;
  logic                       wrAutoPre_ff;
  logic                       wrDone;
  logic                       fifoInValid;
  logic                       fifoInReady;
  logic [FW-1:0]              fifoInData;
  logic                       fifoOutValid;
  logic                       fifoOutReady;
  logic [FW-1:0]              fifoOutData;

  assign wrDone      = wrActive_ff && dqsEdge && (wrBeat_ff == wrLen_ff - 4'h1);
  // beats with every lane masked are dropped here
  assign fifoInValid = wrActive_ff && dqsEdge && !(&dmF);
  assign fifoInData  = {dmF, dqF, wrBank_ff[0], 3'(wrCol_ff + wrBeat_ff[2:0])};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrActive_ff  <= 1'b0;
      wrBeat_ff    <= 4'h0;
      wrLen_ff     <= sca_pkg::BURST_FULL;
      wrBank_ff    <= '0;
      wrCol_ff     <= 3'h0;
      wrAutoPre_ff <= 1'b0;
    end else if (ckRise && cmdNow == sca_pkg::SCA_WR) begin
      wrActive_ff  <= 1'b1;
      wrBeat_ff    <= 4'h0;
      wrLen_ff     <= chopNow ? sca_pkg::BURST_CHOP : sca_pkg::BURST_FULL;
      wrBank_ff    <= bankF;
      wrCol_ff     <= addrF[2:0];
      wrAutoPre_ff <= addrF[sca_pkg::AP_BIT];
    end else if (wrActive_ff && dqsEdge) begin
      wrBeat_ff <= wrBeat_ff + 4'h1;
      if (wrDone) begin
        wrActive_ff <= 1'b0;
      end
    end
  end

  sca_fifo #(
    .W     (FW),
    .DEPTH (sca_pkg::FIFO_DEPTH)
  ) uWrFifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bufferReady_ff <= 1'b1;
    end else begin
      bufferReady_ff <= fifoInReady;
    end
  end

  // ----------------------------------------------------------------------
  // storage array, written per unmasked byte lane
  // ----------------------------------------------------------------------
  logic [sca_pkg::DQ_W-1:0]   memArr [sca_pkg::MEM_DEPTH];
  logic [sca_pkg::MEM_AW-1:0] drainIdx;
  logic [sca_pkg::DM_W-1:0]   drainMask;
  logic                       rdActive_ff;

  // draining waits while a read burst owns the array
  assign fifoOutReady = !rdActive_ff;
  assign drainIdx     = fifoOutData[sca_pkg::MEM_AW-1:0];
  assign drainMask    = fifoOutData[FW-1 -: sca_pkg::DM_W];

  always_ff @(posedge clk) begin
    for (int l = 0; l < sca_pkg::DM_W; l++) begin
      if (fifoOutValid && fifoOutReady && !drainMask[l]) begin
        memArr[drainIdx][8*l +: 8] <= fifoOutData[sca_pkg::MEM_AW + 8*l +: 8];
      end
    end
  end

  // ----------------------------------------------------------------------
  // read burst: data and strobe change on the same clock edge
  // ----------------------------------------------------------------------
  logic [3:0]                 rdBeat_ff;
  logic [3:0]                 rdLen_ff;
  logic [sca_pkg::BANK_W-1:0] rdBank_ff;
  logic [2:0]                 rdCol_ff;
  logic                       rdAutoPre_ff;
  logic                       rdDone;

  assign rdDone = rdActive_ff && ckEdge && !(ckRise && (cmdNow == sca_pkg::SCA_RD)) &&
                  (rdBeat_ff == rdLen_ff);

  function automatic logic ckRise_cmdRd();
    return ckRise && (cmdNow == sca_pkg::SCA_RD);
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdActive_ff  <= 1'b0;
      rdBeat_ff    <= 4'h0;
      rdLen_ff     <= sca_pkg::BURST_FULL;
      rdBank_ff    <= '0;
      rdCol_ff     <= 3'h0;
      rdAutoPre_ff <= 1'b0;
      dqOut_ff     <= sca_pkg::DQ_RESET;
      dqOe_ff      <= 1'b0;
      dqsOut_ff    <= 1'b0;
      dqsOutN_ff   <= 1'b1;
      dqsOe_ff     <= 1'b0;
    end else if (ckRise_cmdRd()) begin
      rdActive_ff  <= 1'b1;
      rdBeat_ff    <= 4'h0;
      rdLen_ff     <= chopNow ? sca_pkg::BURST_CHOP : sca_pkg::BURST_FULL;
      rdBank_ff    <= bankF;
      rdCol_ff     <= addrF[2:0];
      rdAutoPre_ff <= addrF[sca_pkg::AP_BIT];
      dqOe_ff      <= 1'b1;
      dqsOe_ff     <= 1'b1;
      dqsOut_ff    <= 1'b0;
      dqsOutN_ff   <= 1'b1;
    end else if (rdActive_ff && ckEdge) begin
      if (rdDone) begin
        rdActive_ff <= 1'b0;
        dqOe_ff     <= 1'b0;
        dqsOe_ff    <= 1'b0;
        dqsOut_ff   <= 1'b0;
        dqsOutN_ff  <= 1'b1;
      end else begin
        dqOut_ff   <= memArr[{rdBank_ff[0], 3'(rdCol_ff + rdBeat_ff[2:0])}];
        dqsOut_ff  <= !dqsOut_ff;
        dqsOutN_ff <= dqsOut_ff;
        rdBeat_ff  <= rdBeat_ff + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // bank state
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bankOpen_ff <= '0;
    end else begin
      if (wrDone && wrAutoPre_ff) begin
        bankOpen_ff[wrBank_ff] <= 1'b0;
      end
      if (rdDone && rdAutoPre_ff) begin
        bankOpen_ff[rdBank_ff] <= 1'b0;
      end
      if (ckRise && cmdNow == sca_pkg::SCA_ACT) begin
        bankOpen_ff[bankF] <= 1'b1;
      end else if (ckRise && cmdNow == sca_pkg::SCA_PRE) begin
        if (addrF[sca_pkg::AP_BIT]) begin
          bankOpen_ff <= '0;
        end else begin
          bankOpen_ff[bankF] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cbDef @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sqCmd(sca_pkg::sca_cmd_t c);
    ckRise && (cmdNow == c);
  endsequence

  sequence sqRead(logic chop);
    sqCmd(sca_pkg::SCA_RD) and (chopNow == chop);
  endsequence

  AST_DESELECT_IGNORED: assert property (
    ckRise && pinF[sca_pkg::POS_CS] |=> !cmdStrobe_ff)
    else $error("deselected command was accepted");

  AST_ACT_DECODE: assert property (
    sqCmd(sca_pkg::SCA_ACT) |=> cmdStrobe_ff && (cmdCode_ff == sca_pkg::SCA_ACT))
    else $error("activate not decoded");

  AST_ACT_ROW: assert property (
    sqCmd(sca_pkg::SCA_ACT) |=> bankOpen_ff[$past(bankF)] && (cmdRow_ff == $past(addrF)))
    else $error("activate did not open bank with its row");

  AST_PRE_ALL: assert property (
    sqCmd(sca_pkg::SCA_PRE) and addrF[sca_pkg::AP_BIT] |=> (bankOpen_ff == '0))
    else $error("precharge all left a bank open");

  AST_PRE_ONE: assert property (
    sqCmd(sca_pkg::SCA_PRE) and !addrF[sca_pkg::AP_BIT] && !wrDone && !rdDone
    |=> !bankOpen_ff[$past(bankF)] &&
        ((bankOpen_ff | (8'h01 << $past(bankF))) == ($past(bankOpen_ff) | (8'h01 << $past(bankF)))))
    else $error("single precharge touched the wrong bank");

  AST_MRS_LOAD: assert property (
    sqCmd(sca_pkg::SCA_MRS) and (bankF[1:0] == 2'h1) |=> modeRegisterOne_ff == $past(addrF))
    else $error("mode register one not loaded");

  AST_TERMINATION: assert property (
    terminationOn_ff == $past(odtF && rttOn))
    else $error("termination state wrong");

  AST_MASK_BEAT: assert property (
    wrActive_ff && dqsEdge |-> (fifoInValid == !(&dmF)) ##1 (wrBeat_ff == $past(wrBeat_ff) + 4'h1))
    else $error("mask beat not handled");

  AST_MASK_LANE: assert property (
    fifoOutValid && fifoOutReady && drainMask[0] |=> memArr[$past(drainIdx)][7:0] ==
      $past(memArr[drainIdx][7:0]))
    else $error("masked lane was written");

  AST_CHOP_LEN: assert property (
    sqRead(1'b1) |=> rdActive_ff && (rdLen_ff == sca_pkg::BURST_CHOP))
    else $error("chopped read not four beats");

  AST_FULL_LEN: assert property (
    sqRead(1'b0) |=> rdActive_ff && (rdLen_ff == sca_pkg::BURST_FULL))
    else $error("full read not eight beats");

  AST_AUTOPRE_WR: assert property (
    wrDone && wrAutoPre_ff && !ckRise |=> !bankOpen_ff[$past(wrBank_ff)])
    else $error("auto precharge did not close bank");

endmodule // sca_cmd_addr_decode

// *** sca_fifo_note_unused.sv ***
// intentionally empty; fifo logic lives in sca_fifo.sv

// *** sca_ctrl_model.sv ***
// controller model: link clock, command pins, write beats and termination request
`timescale 1ns/1ps
module sca_ctrl_model (
  input  wire logic        clk,
  output logic             ckPin,
  output logic             csPin_n,
  output logic             rasPin_n,
  output logic             casPin_n,
  output logic             wePin_n,
  output logic [2:0]       bankSelect,
  output logic [13:0]      addrPin,
  output logic             terminationEnable,
  output logic [15:0]      dqIn,
  output logic             dqsIn,
  output logic [1:0]       writeDataMask
);
  // ----------------------------------------
  // link clock stands still between commands except while the testbench ticks out a read burst
  // ----------------------------------------
  initial begin
    {ckPin, csPin_n, rasPin_n, casPin_n, wePin_n, terminationEnable} = 6'h1E;
    {bankSelect, addrPin, dqIn, dqsIn, writeDataMask} = '0;
  end
  task automatic tick();
    @(posedge clk);
    ckPin <= ~ckPin;
    repeat (7) @(posedge clk);
  endtask
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(posedge clk);
    {csPin_n, rasPin_n, casPin_n, wePin_n} <= c;
    bankSelect <= b;
    addrPin <= a;
    repeat (4) @(posedge clk);
    tick();
    tick();
    {csPin_n, rasPin_n, casPin_n, wePin_n} <= 4'hF;
    bankSelect <= ~b;
    addrPin <= ~a;
  endtask
  // data set up four clocks before each strobe crossing
  task automatic beat(input logic [15:0] d, input logic [1:0] m);
    @(posedge clk);
    dqIn <= d;
    writeDataMask <= m;
    repeat (4) @(posedge clk);
    dqsIn <= ~dqsIn;
    repeat (4) @(posedge clk);
    dqIn <= ~d;
  endtask
endmodule // sca_ctrl_model

// *** sca_cmd_addr_decode_tb.sv ***
// testbench for the command and address decoder
`timescale 1ns/1ps
module sca_cmd_addr_decode_tb;
  logic clk, rst_n, ckPin, ckPinN, csPin_n, rasPin_n, casPin_n, wePin_n, dqsIn, dqsInN;
  logic terminationEnable, dqOe_ff, dqsOut_ff, dqsOutN_ff, dqsOe_ff, terminationOn_ff;
  logic cmdStrobe_ff, autoPrecharge_ff, burstChopped_ff, prechargeAll_ff, bufferReady_ff;
  logic [2:0]  bankSelect, cmdBank_ff;
  logic [13:0] addrPin, cmdRow_ff, modeRegisterOne_ff, modeRegisterTwo_ff;
  logic [15:0] dqIn, dqOut_ff;
  logic [1:0]  writeDataMask;
  logic [7:0]  bankOpen_ff;
  logic [9:0]  cmdColumn_ff;
  sca_pkg::sca_cmd_t cmdCode_ff;
  int miscompares = 0;
  int compares = 0;
  int strobes = 0;
  logic [15:0] rdExp [4] = '{16'hA000, 16'h5551, 16'hA052, 16'hA003};
  // ----------------------------------------
  // clock, model, design and checks
  // ----------------------------------------
  assign ckPinN = ~ckPin;
  assign dqsInN = ~dqsIn;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  sca_ctrl_model sca_ctrl_model_i (.clk, .ckPin, .csPin_n, .rasPin_n, .casPin_n, .wePin_n,
    .bankSelect, .addrPin, .terminationEnable, .dqIn, .dqsIn, .writeDataMask);
  sca_cmd_addr_decode sca_cmd_addr_decode_i (.clk, .rst_n, .ckPin, .ckPinN, .csPin_n,
    .rasPin_n, .casPin_n, .wePin_n, .bankSelect, .addrPin, .terminationEnable, .dqIn, .dqsIn,
    .dqsInN, .writeDataMask, .dqOut_ff, .dqOe_ff, .dqsOut_ff, .dqsOutN_ff, .dqsOe_ff,
    .terminationOn_ff, .bankOpen_ff, .cmdStrobe_ff, .cmdCode_ff, .cmdBank_ff, .cmdRow_ff,
    .cmdColumn_ff, .autoPrecharge_ff, .burstChopped_ff, .prechargeAll_ff,
    .modeRegisterOne_ff, .modeRegisterTwo_ff, .bufferReady_ff);
  always @(posedge clk) if (cmdStrobe_ff === 1'b1) strobes <= strobes + 1;
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    check("cmdCode", sca_pkg::SCA_NOP, cmdCode_ff);
    check("bufferReady", 16'h0001, bufferReady_ff);
    $display("test reset done");
    sca_ctrl_model_i.issue(4'h3, 3'h5, 14'h1234);
    check("cmdCode", sca_pkg::SCA_ACT, cmdCode_ff);
    check("cmdRow", 16'h1234, cmdRow_ff);
    check("cmdBank", 16'h0005, cmdBank_ff);
    check("bankOpen", 16'h0020, bankOpen_ff);
    sca_ctrl_model_i.issue(4'hB, 3'h2, 14'h0000);
    check("bankOpen", 16'h0020, bankOpen_ff);
    check("strobes", 16'h0001, 16'(strobes));
    sca_ctrl_model_i.issue(4'h3, 3'h0, 14'h0000);
    sca_ctrl_model_i.issue(4'h2, 3'h5, 14'h0000);
    check("bankOpen", 16'h0001, bankOpen_ff);
    check("prechargeAll", 16'h0000, prechargeAll_ff);
    $display("test bank done");
    sca_ctrl_model_i.issue(4'h0, 3'h0, 14'h0001);
    sca_ctrl_model_i.issue(4'h0, 3'h1, 14'h0004);
    check("modeRegisterOne", 16'h0004, modeRegisterOne_ff);
    check("modeRegisterTwo", 16'h0000, modeRegisterTwo_ff);
    sca_ctrl_model_i.terminationEnable <= 1'b1;
    sca_ctrl_model_i.issue(4'hF, 3'h0, 14'h0000);
    check("terminationOn", 16'h0001, terminationOn_ff);
    sca_ctrl_model_i.issue(4'h0, 3'h1, 14'h0000);
    check("terminationOn", 16'h0000, terminationOn_ff);
    sca_ctrl_model_i.terminationEnable <= 1'b0;
    $display("test termination done");
    sca_ctrl_model_i.issue(4'h4, 3'h0, 14'h0008);
    check("cmdColumn", 16'h0008, cmdColumn_ff);
    for (int k = 0; k < 4; k++) sca_ctrl_model_i.beat(16'h5550 + 16'(k), 2'h0);
    sca_ctrl_model_i.issue(4'h4, 3'h0, 14'h0400);
    check("burstChopped", 16'h0001, burstChopped_ff);
    check("autoPrecharge", 16'h0001, autoPrecharge_ff);
    for (int k = 0; k < 4; k++)
      sca_ctrl_model_i.beat(16'hA000 + 16'(k), (k == 1) ? 2'h3 : (k == 2) ? 2'h1 : 2'h0);
    repeat (20) @(posedge clk);
    check("bankOpen", 16'h0000, bankOpen_ff);
    sca_ctrl_model_i.issue(4'h3, 3'h0, 14'h0000);
    sca_ctrl_model_i.issue(4'h5, 3'h0, 14'h0000);
    for (int k = 0; k < 4; k++) begin
      check("dqOut", rdExp[k], dqOut_ff);
      check("dqsOut", 16'(k % 2 == 0), dqsOut_ff);
      check("dqsOutN", 16'(k % 2), dqsOutN_ff);
      check("dqOe", 16'h0001, dqOe_ff);
      sca_ctrl_model_i.tick();
    end
    check("dqOe", 16'h0000, dqOe_ff);
    sca_ctrl_model_i.issue(4'h5, 3'h0, 14'h1000);
    check("burstChopped", 16'h0000, burstChopped_ff);
    for (int k = 0; k < 8; k++) begin
      check("dqsOe", 16'h0001, dqsOe_ff);
      sca_ctrl_model_i.tick();
    end
    check("dqsOe", 16'h0000, dqsOe_ff);
    sca_ctrl_model_i.issue(4'h2, 3'h3, 14'h0400);
    check("prechargeAll", 16'h0001, prechargeAll_ff);
    check("bankOpen", 16'h0000, bankOpen_ff);
    $display("test burst done");
    print_verdict();
  end
endmodule // sca_cmd_addr_decode_tb
